// >>> rhs_pkg.sv
// Shared constants and types for the radio host serial link
package rhs_pkg;
    // Byte geometry
    localparam int          BYTE_W        = 8;
    localparam int          BIT_CNT_W     = 3;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    // Command byte fields
    localparam int          CMD_REG_BIT   = 7;
    localparam int          CMD_WR_BIT    = 6;
    localparam int          CMD_FB_BIT    = 5;
    localparam int          ADDR_W        = 6;
    // Reset value of the radio state byte
    localparam logic [7:0]  STATE_RST     = 8'h00;
    // Filler byte a master sends when it only reads
    localparam logic [7:0]  FILLER        = 8'h00;
    // Serial clock divider for the master: half period in core cycles
    localparam logic [7:0]  SCLK_HALF_DEF = 8'h04;

    // Access targets; the command byte decodes all but the cipher target
    typedef enum logic [1:0] {
        RHS_TGT_REG,
        RHS_TGT_FBUF,
        RHS_TGT_SRAM,
        RHS_TGT_CIPHER
    } rhs_target_t;
endpackage

// >>> rhs_if.sv
// Serial link and side-band lines between host and radio
`timescale 1ns/1ps
interface rhs_if;
    logic chip_en_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic dev_rst_n;
    logic irq;
    logic timestamp_pin;
    logic sleep_transmit_ctrl;
    logic radio_clock_out;
    // Resolved MISO level; the host keeps it defined with a pull-up
    wire  miso = miso_oe ? miso_o : 1'b1;

    modport device (
        input  chip_en_n, sclk, mosi, dev_rst_n, sleep_transmit_ctrl,
        output miso_o, miso_oe, irq, timestamp_pin, radio_clock_out
    );
    modport host (
        output chip_en_n, sclk, mosi, dev_rst_n, sleep_transmit_ctrl,
        input  miso, irq, timestamp_pin, radio_clock_out
    );
endinterface

// >>> rhs_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module rhs_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rhs_sync_t;

    rhs_sync_t st;
    rhs_sync_t next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
        // Reset to the pins' idle levels so no false edge or select follows reset
        if (rst) begin
            next_st.s1 = IDLE;
            next_st.s2 = IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign q = st.s2;
endmodule

// >>> rhs_device.sv
// Radio end of the host serial link: slave shift logic and command decode
// Operation
// - Master lowers chip enable before clocking
// - Eight serial clocks move one byte
// - Device shifts a byte out meanwhile
// - Master sends filler to read
// - Bytes travel most significant bit first
// - Chip enable high ends the access
// - Register access two bytes, buffers longer
// - MISO driven only while chip enabled
// - First bit at select, advance on fall
// - Master keeps MISO level defined
// - Driver also on under select plus reset
// - MOSI sampled on serial clock rise
// - Asynchronous serial clock at most 7.5MHz
// - Clock from radio output means synchronous
// - Radio clock output may be stopped
// - Four targets: registers, buffer, SRAM, cipher; the decode never selects cipher
// - Sleep/transmit line acts by state
// - Interrupt line doubles as buffer-empty flag
// - Reset and chip enable active low
// - Timestamp pin marks receive start or retry
// - First byte is command byte
// - First returned byte is radio state
`timescale 1ns/1ps
module rhs_device #(
    parameter logic [7:0] CLK_DIV_HALF = 8'h02
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Link
    rhs_if.device                        link,
    // Access request to the radio core
    output logic                         acc_valid,
    output logic                         acc_write,
    output rhs_pkg::rhs_target_t         acc_target,
    output logic [rhs_pkg::ADDR_W-1:0]   acc_addr,
    output logic [rhs_pkg::BYTE_W-1:0]   acc_wdata,
    output logic                         acc_first,
    input  wire logic [rhs_pkg::BYTE_W-1:0] acc_rdata,
    output logic                         acc_end,
    // Radio core status and events
    input  wire logic [rhs_pkg::BYTE_W-1:0] radio_state_byte,
    input  wire logic                    irq_event,
    input  wire logic                    fbuf_empty,
    input  wire logic                    fbuf_empty_mode,
    input  wire logic                    rx_start,
    input  wire logic                    tx_frame,
    input  wire logic                    auto_retry_transmit,
    input  wire logic                    clk_out_en,
    // Sleep/transmit line as seen by the radio core
    output logic                         sleep_transmit_rise,
    output logic                         sleep_transmit_level,
    output logic                         dev_reset
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA
    } rhs_phase_t;

    typedef struct packed {
        rhs_phase_t                        phase;
        logic                              sclk_d;
        logic                              slp_d;
        logic [rhs_pkg::BIT_CNT_W-1:0]     bit_cnt;
        logic [rhs_pkg::BYTE_W-1:0]        rx_sh;
        logic [rhs_pkg::BYTE_W-1:0]        tx_sh;
        logic                              is_write;
        rhs_pkg::rhs_target_t              target;
        logic [rhs_pkg::ADDR_W-1:0]        addr;
        logic                              first_data;
        logic                              valid;
        logic [rhs_pkg::BYTE_W-1:0]        wdata;
        logic                              ended;
        logic                              slp_rise;
        logic [7:0]                        div_cnt;
        logic                              clk_out;
    } rhs_dev_t;

    rhs_dev_t st;
    rhs_dev_t next_st;
    logic     sel_n_s;
    logic     sclk_s;
    logic     mosi_s;
    logic     rst_n_s;
    logic     slp_s;

    // Every pin from the host is resynchronised before use
    rhs_sync #(.W(5), .IDLE({1'b1, 1'b0, 1'b0, 1'b1, 1'b0})) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({link.chip_en_n, link.sclk, link.mosi, link.dev_rst_n, link.sleep_transmit_ctrl}),
        .q        ({sel_n_s, sclk_s, mosi_s, rst_n_s, slp_s})
    );

    // Map command byte onto access target
    function automatic rhs_pkg::rhs_target_t decode_target(input logic [7:0] cmd);
        if (cmd[rhs_pkg::CMD_REG_BIT]) begin
            decode_target = rhs_pkg::RHS_TGT_REG;
        end else if (cmd[rhs_pkg::CMD_FB_BIT]) begin
            decode_target = rhs_pkg::RHS_TGT_FBUF;
        end else begin
            decode_target = rhs_pkg::RHS_TGT_SRAM;
        end
    endfunction

    // Serial shift engine, command decode and side-band logic
    always_comb begin
        logic [7:0] rx_full;
        logic       rise;
        logic       fall;
        next_st          = st;
        rx_full          = {st.rx_sh[6:0], mosi_s};
        rise             = sclk_s && !st.sclk_d;
        fall             = !sclk_s && st.sclk_d;
        next_st.sclk_d   = sclk_s;
        next_st.slp_d    = slp_s;
        next_st.slp_rise = slp_s && !st.slp_d;
        next_st.valid    = 1'b0;
        next_st.ended    = 1'b0;
        // First-access marker stays up through the first request only
        if (st.valid) begin
            next_st.first_data = 1'b0;
        end
        // Free-running divided radio clock; may be gated off by the core
        if (st.div_cnt >= CLK_DIV_HALF - 8'h01) begin
            next_st.div_cnt = 8'h00;
            next_st.clk_out = !st.clk_out;
        end else begin
            next_st.div_cnt = st.div_cnt + 8'h01;
        end
        case (st.phase)
            ST_IDLE: begin
                if (!sel_n_s) begin
                    next_st.phase      = ST_CMD;
                    next_st.bit_cnt    = '0;
                    next_st.tx_sh      = radio_state_byte;
                    next_st.first_data = 1'b1;
                end
            end
            ST_CMD, ST_DATA: begin
                if (sel_n_s) begin
                    // Any incomplete byte is simply forgotten
                    next_st.phase = ST_IDLE;
                    next_st.ended = (st.phase == ST_DATA);
                end else begin
                    if (rise) begin
                        next_st.rx_sh   = rx_full;
                        next_st.bit_cnt = st.bit_cnt + 3'h1;
                        if (st.bit_cnt == rhs_pkg::LAST_BIT) begin
                            if (st.phase == ST_CMD) begin
                                next_st.phase    = ST_DATA;
                                next_st.is_write = rx_full[rhs_pkg::CMD_WR_BIT];
                                next_st.target   = decode_target(rx_full);
                                next_st.addr     = rx_full[rhs_pkg::ADDR_W-1:0];
                                // Read request issued early so data is ready
                                next_st.valid    = !rx_full[rhs_pkg::CMD_WR_BIT];
                            end else begin
                                next_st.wdata      = rx_full;
                                next_st.valid      = 1'b1;
                            end
                        end
                    end
                    if (fall) begin
                        if (st.bit_cnt == '0) begin
                            next_st.tx_sh = acc_rdata;
                        end else begin
                            next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
                        end
                    end
                end
            end
            default: begin
                next_st.phase = ST_IDLE;
            end
        endcase
        if (rst) begin
            next_st        = '0;
            next_st.phase  = ST_IDLE;
            next_st.tx_sh  = rhs_pkg::STATE_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    // Access request outputs
    assign acc_valid  = st.valid;
    assign acc_write  = st.is_write && (st.phase != ST_CMD);
    assign acc_target = st.target;
    assign acc_addr   = st.addr;
    assign acc_wdata  = st.wdata;
    assign acc_first  = st.first_data;
    assign acc_end    = st.ended;

    // MISO driver follows select, and also select with reset held
    assign link.miso_o  = st.tx_sh[7];
    assign link.miso_oe = !sel_n_s || (!sel_n_s && !rst_n_s);

    // Side-band outputs
    assign link.irq             = fbuf_empty_mode ? fbuf_empty : irq_event;
    assign link.timestamp_pin   = auto_retry_transmit ? tx_frame : rx_start;
    assign link.radio_clock_out = clk_out_en && st.clk_out;
    assign sleep_transmit_rise  = st.slp_rise;
    assign sleep_transmit_level = st.slp_d;
    assign dev_reset            = !rst_n_s;
endmodule

// >>> rhs_host.sv
// Host end of the serial link: mode-0 master byte engine
`timescale 1ns/1ps
module rhs_host #(
    parameter logic [7:0] SCLK_HALF = rhs_pkg::SCLK_HALF_DEF
) (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // Link
    rhs_if.host                             link,
    // Byte request from host software
    input  wire logic                       start,
    input  wire logic [rhs_pkg::BYTE_W-1:0] tx_byte,
    input  wire logic                       last,
    output logic                            busy,
    output logic                            byte_done,
    output logic [rhs_pkg::BYTE_W-1:0]      rx_byte,
    // Side-band controls
    input  wire logic                       radio_reset,
    input  wire logic                       sleep_transmit_ctrl,
    output logic                            irq,
    output logic                            timestamp_pin
);
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_LOW,
        HS_HIGH,
        HS_WAIT
    } rhs_hphase_t;

    typedef struct packed {
        rhs_hphase_t                   phase;
        logic                          sel_n;
        logic                          sclk;
        logic [7:0]                    cnt;
        logic [rhs_pkg::BIT_CNT_W-1:0] bit_cnt;
        logic [rhs_pkg::BYTE_W-1:0]    tx_sh;
        logic [rhs_pkg::BYTE_W-1:0]    rx_sh;
        logic                          last;
        logic                          done;
    } rhs_host_t;

    rhs_host_t st;
    rhs_host_t next_st;
    logic      miso_s;
    logic      irq_s;
    logic      ts_s;

    rhs_sync #(.W(3), .IDLE({1'b1, 1'b0, 1'b0})) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({link.miso, link.irq, link.timestamp_pin}),
        .q        ({miso_s, irq_s, ts_s})
    );

    // Mode-0 master; serial clock well under the asynchronous limit
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.phase)
            HS_IDLE: begin
                if (start) begin
                    next_st.sel_n   = 1'b0;
                    next_st.tx_sh   = tx_byte;
                    next_st.last    = last;
                    next_st.bit_cnt = '0;
                    next_st.cnt     = '0;
                    next_st.phase   = HS_LOW;
                end
            end
            HS_LOW: begin
                next_st.cnt = st.cnt + 8'h01;
                if (st.cnt >= SCLK_HALF - 8'h01) begin
                    next_st.cnt   = '0;
                    next_st.sclk  = 1'b1;
                    next_st.phase = HS_HIGH;
                end
            end
            HS_HIGH: begin
                next_st.cnt = st.cnt + 8'h01;
                if (st.cnt >= SCLK_HALF - 8'h01) begin
                    next_st.cnt     = '0;
                    next_st.sclk    = 1'b0;
                    // Sample late: the reply needs about five core cycles through both synchronisers
                    next_st.rx_sh   = {st.rx_sh[6:0], miso_s};
                    next_st.tx_sh   = {st.tx_sh[6:0], 1'b0};
                    next_st.bit_cnt = st.bit_cnt + 3'h1;
                    next_st.phase   = (st.bit_cnt == rhs_pkg::LAST_BIT) ? HS_WAIT : HS_LOW;
                end
            end
            HS_WAIT: begin
                next_st.done  = 1'b1;
                next_st.sel_n = st.last;
                next_st.phase = HS_IDLE;
            end
            default: begin
                next_st.phase = HS_IDLE;
            end
        endcase
        if (rst) begin
            next_st       = '0;
            next_st.phase = HS_IDLE;
            next_st.sel_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign link.chip_en_n           = st.sel_n;
    assign link.sclk                = st.sclk;
    assign link.mosi                = st.tx_sh[7];
    assign link.dev_rst_n           = !radio_reset;
    assign link.sleep_transmit_ctrl = sleep_transmit_ctrl;
    assign busy                     = (st.phase != HS_IDLE);
    assign byte_done                = st.done;
    assign rx_byte                  = st.rx_sh;
    assign irq                      = irq_s;
    assign timestamp_pin            = ts_s;
endmodule

// >>> rhs_link_chk.sv
// Timing checker for the serial link between the host and radio ends
`timescale 1ns/1ps
module rhs_link_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link wires
    input wire logic chip_en_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] n_rise;
    logic       sclk_q;
    // Serial clock rises since select; a clean deselect lands on a byte boundary
    always_ff @(posedge core_clk) begin
        sclk_q <= sclk;
        if (rst || chip_en_n) begin
            n_rise <= 8'h00;
        end else if (sclk && !sclk_q) begin
            n_rise <= n_rise + 8'h01;
        end
    end
    property p_sclk_idle;
        chip_en_n |-> !sclk;
    endproperty
    property p_sel_first;
        $rose(sclk) |-> !chip_en_n && $past(!chip_en_n);
    endproperty
    // Host runs with its default half period of four core cycles
    property p_sclk_high;
        $rose(sclk) |-> sclk [*4] ##1 !sclk;
    endproperty
    property p_byte_whole;
        $rose(chip_en_n) |-> n_rise[2:0] == 3'h0 && n_rise != 8'h00;
    endproperty
    property p_mosi_hold;
        sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    property p_miso_hold;
        sclk && $past(sclk) && miso_oe && $past(miso_oe) |-> $stable(miso_o);
    endproperty
    property p_first_bit;
        $rose(sclk) |-> miso_oe;
    endproperty
    property p_oe_on;
        !chip_en_n [*4] |-> miso_oe;
    endproperty
    property p_oe_off;
        chip_en_n [*4] |-> !miso_oe;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock high while deselected");
    a_sel_first: assert property (p_sel_first) else $error("serial clock before select");
    a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase wrong");
    a_byte_whole: assert property (p_byte_whole) else $error("deselect inside a byte");
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while clock high");
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved while clock high");
    a_first_bit: assert property (p_first_bit) else $error("miso undriven at first rise");
    a_oe_on: assert property (p_oe_on) else $error("miso undriven while selected");
    a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
    c_select: cover property ($rose(chip_en_n));
    c_byte: cover property (n_rise == 8'h08);
    c_long: cover property (n_rise == 8'h20);
endmodule

// >>> tb_radio_host_spi_slave.sv
// Bench joining host and radio ends, plus a radio end fed a broken frame
`timescale 1ns/1ps
module tb_radio_host_spi_slave;
    // Bench state
    logic core_clk, rst, clk_q;
    int   n_errors, n_compared, n_cycles, n_acc, n_end, n_acc2, n_slp, n_clk, n_first;
    logic [7:0] wq [$];
    // Host user side
    logic       start, last, busy, byte_done, radio_reset, sleep_transmit_ctrl, h_irq, h_ts;
    logic [7:0] tx_byte, rx_byte;
    // Radio user side
    logic        acc_valid, acc_write, acc_first, acc_end, acc_valid2, irq_event, fbuf_empty, fbuf_empty_mode;
    logic        rx_start, tx_frame, auto_retry_transmit, clk_out_en, slp_rise, slp_level, dev_reset;
    logic [5:0]  acc_addr;
    logic [7:0]  acc_wdata, acc_rdata, radio_state_byte;
    rhs_pkg::rhs_target_t acc_target;

    rhs_if rhs_if_i ();
    rhs_if rhs_if_fault_i ();
    rhs_host rhs_host_i (.core_clk(core_clk), .rst(rst), .link(rhs_if_i.host), .start(start),
        .tx_byte(tx_byte), .last(last), .busy(busy), .byte_done(byte_done), .rx_byte(rx_byte),
        .radio_reset(radio_reset), .sleep_transmit_ctrl(sleep_transmit_ctrl), .irq(h_irq), .timestamp_pin(h_ts));
    rhs_device rhs_device_i (.core_clk(core_clk), .rst(rst), .link(rhs_if_i.device), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_target(acc_target), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_first(acc_first), .acc_rdata(acc_rdata), .acc_end(acc_end), .radio_state_byte(radio_state_byte),
        .irq_event(irq_event), .fbuf_empty(fbuf_empty), .fbuf_empty_mode(fbuf_empty_mode), .rx_start(rx_start),
        .tx_frame(tx_frame), .auto_retry_transmit(auto_retry_transmit), .clk_out_en(clk_out_en),
        .sleep_transmit_rise(slp_rise), .sleep_transmit_level(slp_level), .dev_reset(dev_reset));
    // Second radio end: the bench plays a careless master on its link
    rhs_device rhs_device_fault_i (.core_clk(core_clk), .rst(rst), .link(rhs_if_fault_i.device),
        .acc_valid(acc_valid2), .acc_write(), .acc_target(), .acc_addr(), .acc_wdata(), .acc_first(),
        .acc_rdata(acc_rdata), .acc_end(), .radio_state_byte(radio_state_byte), .irq_event(irq_event),
        .fbuf_empty(fbuf_empty), .fbuf_empty_mode(fbuf_empty_mode), .rx_start(rx_start), .tx_frame(tx_frame),
        .auto_retry_transmit(auto_retry_transmit), .clk_out_en(clk_out_en), .sleep_transmit_rise(),
        .sleep_transmit_level(), .dev_reset());
    rhs_link_chk rhs_link_chk_i (.core_clk(core_clk), .rst(rst), .chip_en_n(rhs_if_i.chip_en_n),
        .sclk(rhs_if_i.sclk), .mosi(rhs_if_i.mosi), .miso_o(rhs_if_i.miso_o), .miso_oe(rhs_if_i.miso_oe));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Event counters and the hang guard
    always @(posedge core_clk) begin
        n_cycles++;
        if (acc_valid === 1'b1) begin
            n_acc++;
            wq.push_back(acc_wdata);
        end
        if (acc_end === 1'b1) n_end++;
        if (acc_valid === 1'b1 && acc_first === 1'b1) n_first++;
        if (acc_valid2 === 1'b1) n_acc2++;
        if (slp_rise === 1'b1) n_slp++;
        if (rhs_if_i.radio_clock_out !== clk_q) n_clk++;
        clk_q = rhs_if_i.radio_clock_out;
        if (n_cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    // One byte through the host engine; waits are bounded
    task automatic xfer(input logic [7:0] tx, input logic lst, output logic [7:0] rx);
        int k;
        tx_byte = tx;
        last = lst;
        start = 1'b1;
        tick();
        start = 1'b0;
        k = 0;
        while (byte_done !== 1'b1 && k < 400) begin
            tick();
            k++;
        end
        rx = rx_byte;
        while (busy !== 1'b0 && k < 400) begin
            tick();
            k++;
        end
        check(8'(k < 400), 8'h01);
    endtask
    // Command byte then nd data bytes; judged at both user sides
    task automatic do_access(input logic [7:0] cmd, input int nd, input logic [7:0] st, input logic [7:0] rd);
        logic [7:0] rx;
        logic       rdacc;
        int         a0, e0, f0;
        rdacc = !cmd[6];
        radio_state_byte = st;
        acc_rdata = rd;
        a0 = n_acc;
        e0 = n_end;
        f0 = n_first;
        wq.delete();
        xfer(cmd, 1'b0, rx);
        check(rx, st);
        for (int i = 0; i < nd; i++) begin
            xfer(rdacc ? rhs_pkg::FILLER : 8'(8'h35 + 17 * i), i == nd - 1, rx);
            if (rdacc) check(rx, rd);
            else check(wq[i], 8'(8'h35 + 17 * i));
        end
        repeat (8) tick();
        check(8'(n_acc - a0), 8'(nd + rdacc));
        check(8'(n_end - e0), 8'h01);
        check(8'(n_first - f0), 8'h01);
        check(8'(acc_write), 8'(cmd[6]));
        check(8'(acc_target), cmd[7] ? 8'(rhs_pkg::RHS_TGT_REG)
            : cmd[5] ? 8'(rhs_pkg::RHS_TGT_FBUF) : 8'(rhs_pkg::RHS_TGT_SRAM));
        if (cmd[7]) check(8'(acc_addr), 8'(cmd[5:0]));
    endtask
    // Register writes and reads at both address ends
    task automatic t_register();
        logic [7:0] cmds [4] = '{8'hEB, 8'h95, 8'hFF, 8'h80};
        foreach (cmds[i]) do_access(cmds[i], 1, 8'hA5 ^ 8'(i), 8'h6E + 8'(i));
    endtask
    // Frame buffer and SRAM in both directions, several data bytes
    task automatic t_buffer();
        logic [7:0] cmds [4] = '{8'h20, 8'h60, 8'h00, 8'h40};
        foreach (cmds[i]) do_access(cmds[i], 2 + i, 8'h3C, 8'hC3 - 8'(i));
    endtask
    // One serial bit at the bench link rate on the second link
    task automatic fault_bit(input logic b, output logic m);
        rhs_if_fault_i.mosi = b;
        #200 rhs_if_fault_i.sclk = 1'b1;
        m = rhs_if_fault_i.miso;
        #200 rhs_if_fault_i.sclk = 1'b0;
    endtask
    // Whole write command, half a data byte, then deselect
    task automatic t_fault();
        logic [7:0] got;
        logic       m;
        int         a0;
        radio_state_byte = 8'hC6;
        a0 = n_acc2;
        #400 rhs_if_fault_i.chip_en_n = 1'b0;
        #400;
        for (int i = 7; i >= 0; i--) fault_bit(1'(8'hC5 >> i), got[i]);
        check(got, 8'hC6);
        for (int i = 0; i < 4; i++) fault_bit(i[0], m);
        #200 rhs_if_fault_i.chip_en_n = 1'b1;
        #600;
        check(8'(n_acc2 - a0), 8'h00);
        check(8'(rhs_if_fault_i.miso_oe), 8'h00);
        rhs_if_fault_i.chip_en_n = 1'b0;
        rhs_if_fault_i.dev_rst_n = 1'b0;
        #400;
        check(8'(rhs_if_fault_i.miso_oe), 8'h01);
        rhs_if_fault_i.chip_en_n = 1'b1;
        rhs_if_fault_i.dev_rst_n = 1'b1;
        tick();
    endtask
    // Interrupt, timestamp, sleep/transmit, reset and clock output lines
    task automatic t_sideband();
        int c0;
        for (int i = 0; i < 4; i++) begin
            fbuf_empty_mode = i[1];
            irq_event = i[1] ? 1'b0 : i[0];
            fbuf_empty = i[1] ? i[0] : !i[0];
            auto_retry_transmit = i[1];
            tx_frame = i[1] ? i[0] : !i[0];
            rx_start = i[1] ? 1'b0 : i[0];
            repeat (8) tick();
            check(8'(h_irq), 8'(i[0]));
            check(8'(h_ts), 8'(i[0]));
        end
        c0 = n_slp;
        sleep_transmit_ctrl = 1'b1;
        radio_reset = 1'b1;
        repeat (8) tick();
        check(8'(slp_level), 8'h01);
        check(8'(n_slp - c0), 8'h01);
        check(8'(dev_reset), 8'h01);
        sleep_transmit_ctrl = 1'b0;
        radio_reset = 1'b0;
        repeat (8) tick();
        check(8'(dev_reset), 8'h00);
        c0 = n_clk;
        repeat (20) tick();
        check(8'(n_clk - c0), 8'h00);
        clk_out_en = 1'b1;
        repeat (20) tick();
        check(8'(n_clk - c0 > 4), 8'h01);
    endtask

    // Main sequence
    initial begin
        {n_errors, n_compared, n_cycles, n_acc, n_end, n_acc2, n_slp, n_clk, n_first} = '0;
        {start, last, radio_reset, sleep_transmit_ctrl, irq_event, fbuf_empty, fbuf_empty_mode} = '0;
        {rx_start, tx_frame, auto_retry_transmit, clk_out_en, clk_q} = '0;
        {tx_byte, acc_rdata, radio_state_byte} = '0;
        {rhs_if_fault_i.chip_en_n, rhs_if_fault_i.dev_rst_n} = 2'h3;
        {rhs_if_fault_i.sclk, rhs_if_fault_i.mosi, rhs_if_fault_i.sleep_transmit_ctrl} = 3'h0;
        rst = 1'b1;
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (4) tick();
        t_register();
        t_buffer();
        t_fault();
        t_sideband();
        final_report();
    end
endmodule
